// file: design/cpm_pkg.sv
// constants and types for the control pin and mode logic
package cpm_pkg;
  localparam int NUM_CH = 8;
  localparam int NUM_IN = 2;
  localparam int NUM_PWM = 2;
  // default input maps: input 0 to channel 2, input 1 to channel 3
  localparam logic [7:0] INPUT0_MAP_RESET = 8'h04;
  localparam logic [7:0] INPUT1_MAP_RESET = 8'h08;
  localparam logic [7:0] OUT_REG_RESET = 8'h00;
  localparam logic [7:0] PWM_MAP_RESET = 8'h00;
  localparam logic ACT_RESET = 1'b0;
  // printed hold times are system constants; given in ns for the clock conversion
  localparam int CLK_PERIOD_NS = 100;
  localparam int SLEEP_ENTRY_HOLD_TIME_NS = 1000;
  localparam int SLEEP_EXIT_HOLD_TIME_NS = 1000;
  localparam int SLEEP_ENTRY_HOLD_CYCLES =
    (SLEEP_ENTRY_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_EXIT_HOLD_CYCLES =
    (SLEEP_EXIT_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CNT_W = 8;
  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_IDLE,
    MODE_ACTIVE,
    MODE_LIMP
  } cpm_mode_t;
endpackage

// file: design/cpm_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module cpm_pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic pinIn,
  output logic pinLevel
);
  logic stage1;
  logic stage2;
  logic stage3;

  // first stage feeds only the second to keep metastability contained
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage1 <= RESET_LEVEL;
      stage2 <= RESET_LEVEL;
      stage3 <= RESET_LEVEL;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts only once the second and third stages agree
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pinLevel <= RESET_LEVEL;
    end else if (stage2 == stage3) begin
      pinLevel <= stage3;
    end
  end
endmodule // cpm_pin_sync

// file: design/cpm_control_pins.sv
// direct control pins, channel drive combination and operation modes
`timescale 1ns/100ps
module cpm_control_pins (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic directInput0Pin,
  input wire logic directInput1Pin,
  input wire logic lowPowerPin,
  input wire logic analogSupplyUv,
  input wire logic digitalSupplyUv,
  input wire logic regWrite,
  input wire logic [7:0] outRegWrData,
  input wire logic [7:0] input0ChannelMapWrData,
  input wire logic [7:0] input1ChannelMapWrData,
  input wire logic [7:0] pwm0MapWrData,
  input wire logic [7:0] pwm1MapWrData,
  input wire logic activeBitWrData,
  input wire logic [1:0] pwmGenActive,
  input wire logic [1:0] pwmGenOut,
  input wire logic serialSelectN,
  input wire logic serialDataOut,
  output logic [7:0] channelOn,
  output logic [7:0] input0ChannelMap,
  output logic [7:0] input1ChannelMap,
  output logic [7:0] outReg,
  output logic [7:0] pwm0Map,
  output logic [7:0] pwm1Map,
  output logic activeBit,
  output logic [1:0] inputLevelMonitor,
  output logic [1:0] opMode,
  output logic uvDetectEnable,
  output logic serialAccessEnable,
  output logic serialDataOutPin,
  output logic serialDataOutEnN
);
  logic inLevel0;
  logic inLevel1;
  logic lowPowerLevel;
  logic [1:0] inLevel;
  logic [7:0] pwmMapped;
  logic [7:0] inMapped;
  logic [7:0] limpChannels;
  logic regsHeldDefault;
  logic serialBlocked;
  logic anyInputHigh;
  logic channelsBlocked;
  cpm_pkg::cpm_mode_t next_mode;
  logic [7:0] next_channelOn;

  cpm_pin_sync #(.RESET_LEVEL(1'b0)) syncIn0 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pinIn(directInput0Pin),
    .pinLevel(inLevel0)
  );
  cpm_pin_sync #(.RESET_LEVEL(1'b0)) syncIn1 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pinIn(directInput1Pin),
    .pinLevel(inLevel1)
  );
  // low-power pin idles high so reset does not look like a sleep request
  cpm_pin_sync #(.RESET_LEVEL(1'b1)) syncLowPower (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pinIn(lowPowerPin),
    .pinLevel(lowPowerLevel)
  );

  assign inLevel = {inLevel1, inLevel0};
  assign anyInputHigh = inLevel0 | inLevel1;
  // low-power low forces registers to defaults
  // digital undervoltage (alone or with analog) resets registers
  assign regsHeldDefault = ~lowPowerLevel | digitalSupplyUv;
  // no serial traffic under digital undervoltage
  assign serialBlocked = (~lowPowerLevel & ~anyInputHigh) | digitalSupplyUv;
  // analog undervoltage blocks every power stage
  assign channelsBlocked = analogSupplyUv;

  always_ff @(posedge core_clk) begin
    if (sys_rst || regsHeldDefault) begin
      input0ChannelMap <= cpm_pkg::INPUT0_MAP_RESET;
      input1ChannelMap <= cpm_pkg::INPUT1_MAP_RESET;
    end else if (regWrite && !serialBlocked) begin
      input0ChannelMap <= input0ChannelMapWrData;
      input1ChannelMap <= input1ChannelMapWrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || regsHeldDefault) begin
      outReg <= cpm_pkg::OUT_REG_RESET;
      pwm0Map <= cpm_pkg::PWM_MAP_RESET;
      pwm1Map <= cpm_pkg::PWM_MAP_RESET;
      activeBit <= cpm_pkg::ACT_RESET;
    end else if (regWrite && !serialBlocked) begin
      outReg <= outRegWrData;
      pwm0Map <= pwm0MapWrData;
      pwm1Map <= pwm1MapWrData;
      activeBit <= activeBitWrData;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < cpm_pkg::NUM_CH; ch++) begin : gChan
      assign pwmMapped[ch] = (pwm0Map[ch] & pwmGenOut[0]) | (pwm1Map[ch] & pwmGenOut[1]);
      assign inMapped[ch] = (input0ChannelMap[ch] & inLevel0) |
                            (input1ChannelMap[ch] & inLevel1);
      // limp-home uses the default maps only
      assign limpChannels[ch] = (cpm_pkg::INPUT0_MAP_RESET[ch] & inLevel0) |
                                (cpm_pkg::INPUT1_MAP_RESET[ch] & inLevel1);
    end
  endgenerate

  // mode decision from pins and control bits
  always_comb begin
    next_mode = cpm_pkg::MODE_IDLE;
    if (!lowPowerLevel) begin
      next_mode = anyInputHigh ? cpm_pkg::MODE_LIMP : cpm_pkg::MODE_SLEEP;
    end else if (activeBit || (outReg != 8'h00) || (pwmGenActive != 2'h0) ||
                 anyInputHigh) begin
      next_mode = cpm_pkg::MODE_ACTIVE;
    end
  end

  always_comb begin
    next_channelOn = 8'h00;
    unique case (next_mode)
      cpm_pkg::MODE_SLEEP: next_channelOn = 8'h00;
      cpm_pkg::MODE_IDLE: next_channelOn = 8'h00;
      cpm_pkg::MODE_ACTIVE: next_channelOn = outReg | pwmMapped | inMapped;
      cpm_pkg::MODE_LIMP: next_channelOn = limpChannels;
    endcase
    // channels return by themselves once the analog supply recovers
    if (channelsBlocked) begin
      next_channelOn = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      channelOn <= 8'h00;
    end else begin
      channelOn <= next_channelOn;
    end
  end

  // monitor runs in every mode, limp-home included
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      inputLevelMonitor <= 2'h0;
    end else begin
      inputLevelMonitor <= inLevel;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      opMode <= 2'h1;
      uvDetectEnable <= 1'b1;
      serialAccessEnable <= 1'b0;
    end else begin
      opMode <= next_mode;
      // detectors off in sleep to save current
      uvDetectEnable <= (next_mode != cpm_pkg::MODE_SLEEP);
      serialAccessEnable <= ~serialBlocked;
    end
  end

  // data output released unless selected and allowed
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      serialDataOutPin <= 1'b0;
      serialDataOutEnN <= 1'b1;
    end else begin
      serialDataOutPin <= serialDataOut;
      serialDataOutEnN <= serialSelectN | serialBlocked;
    end
  end
endmodule // cpm_control_pins

// file: verif/cpm_control_pins_sva.sv
// assertions on the control pin and mode logic ports
`timescale 1ns/100ps
module cpm_control_pins_sva (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic directInput0Pin,
  input wire logic directInput1Pin,
  input wire logic lowPowerPin,
  input wire logic analogSupplyUv,
  input wire logic digitalSupplyUv,
  input wire logic [7:0] channelOn,
  input wire logic [7:0] input0ChannelMap,
  input wire logic [7:0] input1ChannelMap,
  input wire logic [7:0] outReg,
  input wire logic [1:0] inputLevelMonitor,
  input wire logic [1:0] opMode,
  input wire logic uvDetectEnable,
  input wire logic serialAccessEnable,
  input wire logic serialDataOutEnN
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_reset_maps:
    assert property ($past(sys_rst) |-> input0ChannelMap == 8'h04 && input1ChannelMap == 8'h08)
      else $error("maps");
  a_analog_uv:
    assert property (analogSupplyUv |=> channelOn == 8'h00) else $error("uv drive");
  a_both_uv:
    assert property (analogSupplyUv && digitalSupplyUv |=> !serialAccessEnable && outReg == 8'h00)
      else $error("both uv");
  a_digital_uv:
    assert property (digitalSupplyUv |=> !serialAccessEnable && input1ChannelMap == 8'h08)
      else $error("dig uv");
  a_lowpower_defaults:
    assert property ((!lowPowerPin)[*6] |=> outReg == 8'h00 && input0ChannelMap == 8'h04)
      else $error("defaults");
  a_sleep_mode:
    assert property ((!lowPowerPin && !directInput0Pin && !directInput1Pin)[*6]
      |=> opMode == cpm_pkg::MODE_SLEEP && !uvDetectEnable) else $error("sleep");
  a_sleep_serial:
    assert property ((!lowPowerPin && !directInput0Pin && !directInput1Pin)[*6]
      |=> !serialAccessEnable && serialDataOutEnN) else $error("serial");
  a_limp_mode:
    assert property ((!lowPowerPin && directInput0Pin && !analogSupplyUv)[*6]
      |=> opMode == cpm_pkg::MODE_LIMP && channelOn[2]) else $error("limp");
  a_input_monitor:
    assert property (directInput0Pin[*6] |=> inputLevelMonitor[0]) else $error("monitor");
endmodule // cpm_control_pins_sva

// file: verif/cpm_mcu_model.sv
// controller model driving the direct input and low-power pins
`timescale 1ns/100ps
module cpm_mcu_model (
  input wire logic core_clk,
  input wire logic [1:0] wantIn,
  input wire logic wantLowPower,
  output logic directInput0Pin,
  output logic directInput1Pin,
  output logic lowPowerPin
);
  int holdCnt = 0;
  initial begin
    directInput0Pin = 1'b0;
    directInput1Pin = 1'b0;
    lowPowerPin = 1'b1;
  end
  // hold before move
  // a low-power request is delayed until the present low-power level has been held long enough
  always @(negedge core_clk) begin
    {directInput1Pin, directInput0Pin} <= wantIn;
    if (wantLowPower != lowPowerPin && holdCnt >= (lowPowerPin ?
        cpm_pkg::SLEEP_ENTRY_HOLD_CYCLES : cpm_pkg::SLEEP_EXIT_HOLD_CYCLES)) begin
      lowPowerPin <= wantLowPower;
      holdCnt <= 0;
    end else if (holdCnt < 255) begin
      holdCnt <= holdCnt + 1;
    end
  end
endmodule // cpm_mcu_model

// file: verif/tb.sv
// self-checking bench for the control pin and mode logic
`timescale 1ns/100ps
module tb;
  logic core_clk = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, activeBitWrData = 1'b0;
  logic analogSupplyUv = 1'b0, digitalSupplyUv = 1'b0, wantLowPower = 1'b1;
  logic serialSelectN = 1'b0, serialDataOut = 1'b1;
  logic directInput0Pin, directInput1Pin, lowPowerPin;
  logic [1:0] wantIn = 2'h0, pwmGenActive = 2'h0, pwmGenOut = 2'h0;
  logic [7:0] outRegWrData = 8'h00, input0ChannelMapWrData = 8'h04, pwm0MapWrData = 8'h00;
  logic [7:0] input1ChannelMapWrData = 8'h08, pwm1MapWrData = 8'h40;
  logic [7:0] channelOn, input0ChannelMap, input1ChannelMap, outReg, pwm0Map, pwm1Map;
  logic [1:0] inputLevelMonitor, opMode;
  logic activeBit, uvDetectEnable, serialAccessEnable, serialDataOutPin, serialDataOutEnN;
  int fails = 0, checksDone = 0, testNo = 0;
  always #50 core_clk = ~core_clk;
  cpm_mcu_model cpm_mcu_model_i (.core_clk, .wantIn, .wantLowPower, .directInput0Pin,
    .directInput1Pin, .lowPowerPin);
  cpm_control_pins cpm_control_pins_i (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] m0, input logic [7:0] p0);
    @(negedge core_clk);
    {outRegWrData, input0ChannelMapWrData, pwm0MapWrData, regWrite} <= {o, m0, p0, 1'b1};
    @(negedge core_clk);
    regWrite <= 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic drive(input logic [1:0] i, input logic lp, input logic a, input logic d,
      input int n);
    @(negedge core_clk);
    {wantIn, wantLowPower, analogSupplyUv, digitalSupplyUv} <= {i, lp, a, d};
    repeat (n) @(negedge core_clk);
    testNo++;
    $display("test %0d done", testNo);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (8) @(negedge core_clk);
    sys_rst <= 1'b0;
    drive(2'h0, 1'b1, 1'b0, 1'b0, 4);
    chk({input1ChannelMap, input0ChannelMap} == 16'h0804, 8'h01);
    chk({6'h0, opMode}, 8'h01);
    drive(2'h1, 1'b1, 1'b0, 1'b0, 8);
    chk(channelOn, 8'h04);
    chk({6'h0, inputLevelMonitor}, 8'h01);
    chk({5'h0, opMode, serialAccessEnable}, 8'h05);
    chk({6'h0, serialDataOutEnN, serialDataOutPin}, 8'h01);
    {pwmGenActive, pwmGenOut} <= 4'h5;
    wr(8'h10, 8'h81, 8'h20);
    chk(input0ChannelMap, 8'h81);
    chk(channelOn, 8'hb1);
    chk(pwm0Map, 8'h20);
    chk(pwm1Map, 8'h40);
    drive(2'h1, 1'b1, 1'b1, 1'b0, 2);
    chk(channelOn, 8'h00);
    drive(2'h1, 1'b1, 1'b0, 1'b0, 2);
    chk(channelOn, 8'hb1);
    drive(2'h1, 1'b1, 1'b0, 1'b1, 2);
    chk({outReg[6:0], serialAccessEnable}, 8'h00);
    drive(2'h1, 1'b1, 1'b0, 1'b0, 2);
    chk(channelOn, 8'h04);
    wr(8'h10, 8'h81, 8'h20);
    drive(2'h1, 1'b0, 1'b0, 1'b0, 20);
    chk({outReg[5:0], opMode}, 8'h03);
    chk({channelOn[6:0], inputLevelMonitor[0]}, 8'h09);
    drive(2'h0, 1'b0, 1'b0, 1'b0, 12);
    chk({4'h0, opMode, uvDetectEnable, serialAccessEnable}, 8'h00);
    chk({7'h0, serialDataOutEnN}, 8'h01);
    wr(8'h10, 8'h81, 8'h20);
    chk(outReg, 8'h00);
    drive(2'h2, 1'b1, 1'b1, 1'b1, 16);
    chk({channelOn[6:0], serialAccessEnable}, 8'h00);
    drive(2'h2, 1'b1, 1'b0, 1'b0, 8);
    chk(channelOn, 8'h08);
    {pwmGenActive, pwmGenOut, activeBitWrData} <= 5'h01;
    wr(8'h00, 8'h04, 8'h00);
    drive(2'h0, 1'b1, 1'b0, 1'b0, 8);
    chk({5'h0, activeBit, opMode}, 8'h06);
    chk(channelOn, 8'h00);
    complete_run();
  end
endmodule // tb
bind cpm_control_pins cpm_control_pins_sva cpm_control_pins_sva_i (.*);
